/* File: rtl/mpio_top.sv */
// Three-bank general purpose port with peripheral override and parallel slave mode
//
// Summary of operation
// - Direction bit 1 makes the pin an input with driver off.
// - Direction bit 0 drives the pin from its output latch.
// - Bank C has eight pins, each with latch and direction bit.
// - An enabled peripheral overrides its bank C pin direction.
// - Bank C pin output muxes peripheral output or latch by select.
// - Peripheral output enable acts only while its select is active.
// - Bank C bits 0,1,2,5,6,7 carry timer, PWM, SPI and USART lines.
// - Bank C bit3 is serial clock, bit4 serial data.
// - Data latches cleared to zero at power-on, kept on other resets.
// - Bank C and D directions reset to all inputs on any reset.
// - Bank D has eight pins, each with its own direction bit.
// - Slave mode bit turns bank D into an 8-bit slave data port.
// - In slave mode pin n carries bit n of the data byte.
// - Bank E has three pins set by low three control bits.
// - In slave mode bank E pins are the slave port strobes.
// - Bank E pins selected analog read back as zero.
// - Bank E direction bits drive pins even when analog.
// - After power-on bank E pins are analog inputs.
// - Control bit 3 reads zero; reset gives flags clear, directions set.
// - Overflow flag sets on external write while byte unread.
// - Selected read strobe presents the byte; write strobe loads it.
// - Input and output buffer full flags show pending bytes.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "mpio_defs.svh"

module mpio_top #(
    parameter int ADDR_W = 12,
    parameter bit HAS_SLAVE_PORT = 1'b1
) (
    input wire logic CLK, // Core clock
    input wire logic SYS_RST, // Any reset, sync high
    input wire logic POR_RST, // Power-on or brown-out reset, sync high
    input wire logic [ADDR_W-1:0] AWADDR, // Write address
    input wire logic AWVALID, // Write address valid
    output logic AWREADY, // Write address ready
    input wire logic [31:0] WDATA, // Write data
    input wire logic [3:0] WSTRB, // Write byte lanes
    input wire logic WVALID, // Write data valid
    output logic WREADY, // Write data ready
    output logic [1:0] BRESP, // Write answer
    output logic BVALID, // Write answer valid
    input wire logic BREADY, // Write answer ready
    input wire logic [ADDR_W-1:0] ARADDR, // Read address
    input wire logic ARVALID, // Read address valid
    output logic ARREADY, // Read address ready
    output logic [31:0] RDATA, // Read data
    output logic [1:0] RRESP, // Read answer
    output logic RVALID, // Read answer valid
    input wire logic RREADY, // Read answer ready
    input wire mpio_pkg::mpio_byte_type C_IN, // Bank C pin levels
    output mpio_pkg::mpio_byte_type C_OUT, // Bank C pin drive
    output mpio_pkg::mpio_byte_type C_OE_N, // Bank C drive enable, low drives
    input wire mpio_pkg::mpio_byte_type PERIPH_SEL, // Peripheral owns pin
    input wire mpio_pkg::mpio_byte_type PERIPH_OUT, // Peripheral output level
    input wire mpio_pkg::mpio_byte_type PERIPH_OE, // Peripheral wants to drive
    input wire mpio_pkg::mpio_byte_type D_IN, // Bank D pin levels
    output mpio_pkg::mpio_byte_type D_OUT, // Bank D pin drive
    output mpio_pkg::mpio_byte_type D_OE_N, // Bank D drive enable, low drives
    input wire mpio_pkg::mpio_tri_type E_IN, // Bank E pin levels
    output mpio_pkg::mpio_tri_type E_OUT, // Bank E pin drive
    output mpio_pkg::mpio_tri_type E_OE_N, // Bank E drive enable, low drives
    output logic SLAVE_MODE // Slave port mode active
);
    import mpio_pkg::*;

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[9:2];
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        reg_mapped = (a[ADDR_W-1:10] == '0) && (i == `MPIO_IDX_C_DATA || i == `MPIO_IDX_D_DATA
            || i == `MPIO_IDX_E_DATA || i == `MPIO_IDX_C_DIR || i == `MPIO_IDX_D_DIR
            || i == `MPIO_IDX_E_CTRL || i == `MPIO_IDX_ANALOG);
    endfunction

    // ****************************************
    // Bus slave state
    // ****************************************
    mpio_bus_state_type wr_st_q, wr_st_d, rd_st_q, rd_st_d;
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // ****************************************
    // Port state
    // ****************************************
    mpio_byte_type c_lat_q, c_lat_d, d_lat_q, d_lat_d;
    mpio_byte_type c_dir_q, c_dir_d, d_dir_q, d_dir_d;
    mpio_tri_type e_lat_q, e_lat_d, e_dir_q, e_dir_d, ana_q, ana_d;
    logic mode_q, mode_d, ibf_q, ibf_d, obf_q, obf_d, input_buffer_overflow_flag_q, input_buffer_overflow_flag_d;
    mpio_byte_type in_buf_q, in_buf_d, cap_q, cap_d;
    logic rd_act_q, wr_act_q;

    wire any_rst = SYS_RST | POR_RST;
    wire wr_go = aw_have_q & w_have_q & (wr_st_q == MPIO_IDLE);
    wire [7:0] wr_idx = reg_index(aw_addr_q);
    wire wr_ok = reg_mapped(aw_addr_q);
    wire wr_take = wr_go & wr_ok & w_lane_q;
    wire wr_c = wr_take & (wr_idx == `MPIO_IDX_C_DATA);
    wire wr_d = wr_take & (wr_idx == `MPIO_IDX_D_DATA);
    wire wr_e = wr_take & (wr_idx == `MPIO_IDX_E_DATA);
    wire wr_cdir = wr_take & (wr_idx == `MPIO_IDX_C_DIR);
    wire wr_ddir = wr_take & (wr_idx == `MPIO_IDX_D_DIR);
    wire wr_ctrl = wr_take & (wr_idx == `MPIO_IDX_E_CTRL);
    wire wr_ana = wr_take & (wr_idx == `MPIO_IDX_ANALOG);
    wire [7:0] wd = w_data_q[7:0];

    wire ar_fire = ARVALID & ARREADY;
    wire [7:0] ar_idx = reg_index(ARADDR);
    wire ar_ok = reg_mapped(ARADDR);
    wire slave_on = HAS_SLAVE_PORT & mode_q;

    // ****************************************
    // Slave port strobes
    // ****************************************
    // Strobes sampled straight from the pins, which arrive synchronous to CLK
    wire stb_rd_n = E_IN[`MPIO_STB_READ];
    wire stb_wr_n = E_IN[`MPIO_STB_WRITE];
    wire stb_cs_n = E_IN[`MPIO_STB_CS];
    wire rd_act = slave_on & ~stb_cs_n & ~stb_rd_n;
    wire wr_act = slave_on & ~stb_cs_n & ~stb_wr_n;
    wire ext_wr_end = wr_act_q & ~wr_act;
    wire ext_rd_end = rd_act_q & ~rd_act;
    wire cpu_rd_d = ar_fire & ar_ok & (ar_idx == `MPIO_IDX_D_DATA) & slave_on;

    // ****************************************
    // Pin drive
    // ****************************************
    // Bit map of the selects: 0 timer osc out/clock in, 1 timer osc in/PWM two,
    // 2 PWM one, 3 serial clock, 4 serial data, 5 SPI out, 6 USART tx, 7 USART rx
    wire [7:0] c_eff_dir = (PERIPH_SEL & ~PERIPH_OE) | (~PERIPH_SEL & c_dir_q);
    assign C_OUT = (PERIPH_SEL & PERIPH_OUT) | (~PERIPH_SEL & c_lat_q);
    assign C_OE_N = c_eff_dir;
    assign D_OUT = d_lat_q;
    assign D_OE_N = slave_on ? {8{~rd_act}} : d_dir_q;
    assign E_OUT = e_lat_q;
    // Direction still rules the driver on analog pins
    assign E_OE_N = e_dir_q;
    assign SLAVE_MODE = slave_on;

    // ****************************************
    // Read decode
    // ****************************************
    wire [7:0] ctrl_rd = {ibf_q, obf_q, input_buffer_overflow_flag_q, mode_q, 1'b0, e_dir_q};
    wire [7:0] e_rd = {5'h00, E_IN & ~ana_q};
    wire [7:0] d_rd = slave_on ? in_buf_q : D_IN;
    wire [7:0] rd_byte =
        (ar_idx == `MPIO_IDX_C_DATA) ? C_IN :
        (ar_idx == `MPIO_IDX_D_DATA) ? d_rd :
        (ar_idx == `MPIO_IDX_E_DATA) ? e_rd :
        // Returns overridden directions, so RMW here is unsafe
        (ar_idx == `MPIO_IDX_C_DIR) ? c_eff_dir :
        (ar_idx == `MPIO_IDX_D_DIR) ? d_dir_q :
        (ar_idx == `MPIO_IDX_E_CTRL) ? ctrl_rd :
        (ar_idx == `MPIO_IDX_ANALOG) ? {5'h00, ana_q} : 8'h00;

    // ****************************************
    // Next values
    // ****************************************
    assign c_lat_d = wr_c ? wd : c_lat_q;
    assign d_lat_d = wr_d ? wd : d_lat_q;
    assign e_lat_d = wr_e ? wd[2:0] : e_lat_q;
    assign c_dir_d = wr_cdir ? wd : c_dir_q;
    assign d_dir_d = wr_ddir ? wd : d_dir_q;
    assign e_dir_d = wr_ctrl ? wd[2:0] : e_dir_q;
    assign ana_d = wr_ana ? wd[2:0] : ana_q;
    assign mode_d = wr_ctrl ? wd[`MPIO_BIT_MODE] : mode_q;
    assign cap_d = wr_act ? D_IN : cap_q;
    assign in_buf_d = ext_wr_end ? cap_q : in_buf_q;
    // Set wins over clear on every flag
    assign ibf_d = ext_wr_end | (ibf_q & ~cpu_rd_d);
    assign obf_d = (wr_d & slave_on) | (obf_q & ~ext_rd_end);
    assign input_buffer_overflow_flag_d = (ext_wr_end & ibf_q) | (wr_ctrl ? wd[`MPIO_BIT_INPUT_BUFFER_OVERFLOW_FLAG] : input_buffer_overflow_flag_q);

    always_ff @(posedge CLK) begin
        if (POR_RST) begin
            c_lat_q <= `MPIO_LATCH_POR;
            d_lat_q <= `MPIO_LATCH_POR;
            e_lat_q <= `MPIO_ELATCH_POR;
        end else if (!SYS_RST) begin
            // A warm reset must not let a pending bus write slip into the latches
            c_lat_q <= c_lat_d;
            d_lat_q <= d_lat_d;
            e_lat_q <= e_lat_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            c_dir_q <= `MPIO_DIR_RST;
            d_dir_q <= `MPIO_DIR_RST;
            e_dir_q <= `MPIO_EDIR_RST;
            ana_q <= `MPIO_ANALOG_RST;
            mode_q <= 1'b0;
        end else begin
            c_dir_q <= c_dir_d;
            d_dir_q <= d_dir_d;
            e_dir_q <= e_dir_d;
            ana_q <= ana_d;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            ibf_q <= 1'b0;
            obf_q <= 1'b0;
            input_buffer_overflow_flag_q <= 1'b0;
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            in_buf_q <= 8'h00;
            cap_q <= 8'h00;
        end else begin
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            input_buffer_overflow_flag_q <= input_buffer_overflow_flag_d;
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            in_buf_q <= in_buf_d;
            cap_q <= cap_d;
        end
    end

    // ****************************************
    // AXI4-Lite channels
    // ****************************************
    assign AWREADY = ~aw_have_q & (wr_st_q == MPIO_IDLE);
    assign WREADY = ~w_have_q & (wr_st_q == MPIO_IDLE);
    assign BVALID = (wr_st_q == MPIO_RESP);
    assign BRESP = bresp_q;
    assign ARREADY = (rd_st_q == MPIO_IDLE);
    assign RVALID = (rd_st_q == MPIO_RESP);
    assign RRESP = rresp_q;
    assign RDATA = rdata_q;

    always_comb begin
        case (wr_st_q)
            MPIO_IDLE: wr_st_d = wr_go ? MPIO_RESP : MPIO_IDLE;
            MPIO_RESP: wr_st_d = BREADY ? MPIO_IDLE : MPIO_RESP;
            default: wr_st_d = MPIO_IDLE;
        endcase
    end

    always_comb begin
        case (rd_st_q)
            MPIO_IDLE: rd_st_d = ARVALID ? MPIO_RESP : MPIO_IDLE;
            MPIO_RESP: rd_st_d = RREADY ? MPIO_IDLE : MPIO_RESP;
            default: rd_st_d = MPIO_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            wr_st_q <= MPIO_IDLE;
            rd_st_q <= MPIO_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
        end else begin
            wr_st_q <= wr_st_d;
            rd_st_q <= rd_st_d;
            aw_have_q <= (aw_have_q | (AWVALID & AWREADY)) & ~wr_go;
            w_have_q <= (w_have_q | (WVALID & WREADY)) & ~wr_go;
        end
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            aw_addr_q <= '0;
            w_data_q <= 32'h00000000;
            w_lane_q <= 1'b0;
            bresp_q <= `MPIO_RESP_OKAY;
            rresp_q <= `MPIO_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            if (AWVALID & AWREADY) begin
                aw_addr_q <= AWADDR;
            end
            if (WVALID & WREADY) begin
                w_data_q <= WDATA;
                w_lane_q <= WSTRB[0];
            end
            if (wr_go) begin
                bresp_q <= wr_ok ? `MPIO_RESP_OKAY : `MPIO_RESP_SLVERR;
            end
            if (ar_fire) begin
                rresp_q <= ar_ok ? `MPIO_RESP_OKAY : `MPIO_RESP_SLVERR;
                rdata_q <= ar_ok ? {24'h000000, rd_byte} : 32'h00000000;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_cdir_wr;
        wr_cdir && (PERIPH_SEL == 8'h00);
    endsequence

    sequence s_idx_rd(logic [7:0] idx);
        ar_fire && ar_ok && (ar_idx == idx);
    endsequence

    dir_write_pins_a: assert property (@(posedge CLK) disable iff (any_rst)
        s_cdir_wr ##1 (PERIPH_SEL == 8'h00) |-> (C_OE_N == $past(wd))
        && ((C_OUT & ~C_OE_N) == (c_lat_q & ~C_OE_N)))
        else $error("bank C direction write not reflected on pins");

    periph_takeover_a: assert property (@(posedge CLK) disable iff (any_rst)
        $rose(PERIPH_SEL[5]) |-> (C_OUT[5] == PERIPH_OUT[5]) && (C_OE_N[5] == !PERIPH_OE[5]))
        else $error("peripheral select does not take over the pin");

    dir_reset_ones_a: assert property (@(posedge CLK)
        SYS_RST |=> (c_dir_q == 8'hFF) && (d_dir_q == 8'hFF) && ((C_OE_N | PERIPH_SEL) == 8'hFF))
        else $error("direction registers not all inputs after reset");

    latch_keep_a: assert property (@(posedge CLK)
        (SYS_RST && !POR_RST) |=> (c_lat_q == $past(c_lat_q)) && (d_lat_q == $past(d_lat_q)))
        else $error("data latch disturbed by a warm reset");

    slave_drive_a: assert property (@(posedge CLK) disable iff (any_rst)
        (slave_on && !stb_cs_n && !stb_rd_n) |-> (D_OE_N == 8'h00) && (D_OUT == d_lat_q))
        else $error("slave read does not present the data byte");

    ibf_load_a: assert property (@(posedge CLK) disable iff (any_rst)
        ext_wr_end |=> ibf_q && (in_buf_q == $past(cap_q)))
        else $error("external write did not fill the input buffer");

    input_buffer_overflow_flag_set_a: assert property (@(posedge CLK) disable iff (any_rst)
        (ext_wr_end && ibf_q) |=> input_buffer_overflow_flag_q)
        else $error("overflow not flagged on write over unread byte");

    obf_set_a: assert property (@(posedge CLK) disable iff (any_rst)
        (wr_d && slave_on) |=> obf_q && (D_OUT == $past(wd)))
        else $error("output buffer flag not set by processor write");

    analog_zero_a: assert property (@(posedge CLK) disable iff (any_rst)
        s_idx_rd(`MPIO_IDX_E_DATA) |=> RVALID && ((RDATA[2:0] & $past(ana_q)) == 3'h0))
        else $error("analog pin did not read as zero");

    ctrl_bit3_a: assert property (@(posedge CLK) disable iff (any_rst)
        s_idx_rd(`MPIO_IDX_E_CTRL) |=> RVALID && (RDATA[3] == 1'b0) && (RDATA[31:8] == 24'h000000))
        else $error("unimplemented control bit read nonzero");

    pin_read_a: assert property (@(posedge CLK) disable iff (any_rst)
        s_idx_rd(`MPIO_IDX_C_DATA) |=> RVALID && (RDATA[7:0] == $past(C_IN)))
        else $error("bank C read does not return pin levels");

    por_analog_a: assert property (@(posedge CLK)
        POR_RST |=> (ana_q == 3'h7) && (e_dir_q == 3'h7) && !ibf_q && !obf_q && !input_buffer_overflow_flag_q)
        else $error("bank E not analog inputs after power-on");
endmodule

/* File: rtl/mpio_defs.svh */
// Register indices, field positions, reset values and bus answers of the port block
`ifndef MPIO_DEFS_SVH
`define MPIO_DEFS_SVH
`define MPIO_IDX_C_DATA 8'h07
`define MPIO_IDX_D_DATA 8'h08
`define MPIO_IDX_E_DATA 8'h09
`define MPIO_IDX_C_DIR 8'h87
`define MPIO_IDX_D_DIR 8'h88
`define MPIO_IDX_E_CTRL 8'h89
`define MPIO_IDX_ANALOG 8'h9F
`define MPIO_DIR_RST 8'hFF
`define MPIO_EDIR_RST 3'h7
`define MPIO_ANALOG_RST 3'h7
`define MPIO_LATCH_POR 8'h00
`define MPIO_ELATCH_POR 3'h0
`define MPIO_BIT_IBF 7
`define MPIO_BIT_OBF 6
`define MPIO_BIT_INPUT_BUFFER_OVERFLOW_FLAG 5
`define MPIO_BIT_MODE 4
`define MPIO_STB_READ 0
`define MPIO_STB_WRITE 1
`define MPIO_STB_CS 2
`define MPIO_RESP_OKAY 2'h0
`define MPIO_RESP_SLVERR 2'h2
`endif

/* File: rtl/mpio_pkg.sv */
// Types shared by the port block
package mpio_pkg;
    typedef logic [7:0] mpio_byte_type;
    typedef logic [2:0] mpio_tri_type;
    typedef enum logic [1:0] {
        MPIO_IDLE = 2'b01,
        MPIO_RESP = 2'b10
    } mpio_bus_state_type;
endpackage

/* File: bench/mpio_pin_model.sv */
// Outside world of one port bank: drivers sharing each pin with the block
`timescale 1ns/1ps
// ****************************************
// Pin resolution
// ****************************************
module mpio_pin_model #(
    parameter int W = 8
) (
    input wire logic clk, // Core clock
    input wire logic [W-1:0] dout, // Block drive level
    input wire logic [W-1:0] oe_n, // Block drives when low
    input wire logic [W-1:0] ext, // Outside drive level
    input wire logic [W-1:0] ext_en, // Outside drives when high
    output logic [W-1:0] lvl // Resolved pin level
);
    logic [W-1:0] last_q = '0;
    // Floating pins toggle so a stale value never passes for a real one
    assign lvl = (~oe_n & dout) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & ~last_q);
    always @(posedge clk) begin
        last_q <= lvl;
    end
endmodule

/* File: bench/multi_port_io_with_psp_mux_test.sv */
// Self-checking bench for the three-bank port block
`timescale 1ns/1ps
`include "mpio_defs.svh"
module multi_port_io_with_psp_mux_test;
    import mpio_pkg::*;
    localparam logic [11:0] A_CD = {2'h0, `MPIO_IDX_C_DATA, 2'h0};
    localparam logic [11:0] A_DD = {2'h0, `MPIO_IDX_D_DATA, 2'h0};
    localparam logic [11:0] A_ED = {2'h0, `MPIO_IDX_E_DATA, 2'h0};
    localparam logic [11:0] A_CT = {2'h0, `MPIO_IDX_C_DIR, 2'h0};
    localparam logic [11:0] A_DT = {2'h0, `MPIO_IDX_D_DIR, 2'h0};
    localparam logic [11:0] A_EC = {2'h0, `MPIO_IDX_E_CTRL, 2'h0};
    localparam logic [11:0] A_AN = {2'h0, `MPIO_IDX_ANALOG, 2'h0};
    logic clk = 1'h0, sys_rst = 1'h1, por_rst = 1'h1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, smode;
    logic [1:0] bresp, rresp, rsp;
    mpio_byte_type c_in, c_out, c_oe_n, d_in, d_out, d_oe_n, rd, lat, dir, v;
    mpio_byte_type psel = '0, pout = '0, poe = '0, c_ext = '0, c_en = 8'hFF, d_ext = '0, d_en = 8'hFF;
    mpio_tri_type e_in, e_out, e_oe_n, e_ext = 3'h7, e_en = 3'h7;
    int n_mismatch = 0, total_checks = 0;
    always #5 clk = ~clk;
    mpio_top uut (.CLK(clk), .SYS_RST(sys_rst), .POR_RST(por_rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .C_IN(c_in), .C_OUT(c_out),
        .C_OE_N(c_oe_n), .PERIPH_SEL(psel), .PERIPH_OUT(pout), .PERIPH_OE(poe), .D_IN(d_in),
        .D_OUT(d_out), .D_OE_N(d_oe_n), .E_IN(e_in), .E_OUT(e_out), .E_OE_N(e_oe_n), .SLAVE_MODE(smode));
    mpio_pin_model #(.W(8)) pc (.clk(clk), .dout(c_out), .oe_n(c_oe_n), .ext(c_ext), .ext_en(c_en), .lvl(c_in));
    mpio_pin_model #(.W(8)) pd (.clk(clk), .dout(d_out), .oe_n(d_oe_n), .ext(d_ext), .ext_en(d_en), .lvl(d_in));
    mpio_pin_model #(.W(3)) pe (.clk(clk), .dout(e_out), .oe_n(e_oe_n), .ext(e_ext), .ext_en(e_en), .lvl(e_in));
    // ****************************************
    // Expectations and checks
    // ****************************************
    function automatic mpio_byte_type f_cout(mpio_byte_type s, mpio_byte_type po, mpio_byte_type l);
        return (s & po) | (~s & l);
    endfunction
    function automatic mpio_byte_type f_cdir(mpio_byte_type s, mpio_byte_type oe, mpio_byte_type t);
        return (s & ~oe) | (~s & t);
    endfunction
    function automatic mpio_byte_type f_pin(mpio_byte_type oen, mpio_byte_type o, mpio_byte_type x);
        return (~oen & o) | (oen & x);
    endfunction
    task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        wrap_up();
    endtask
    task automatic axi_wr(input logic [11:0] a, input mpio_byte_type d, input logic [3:0] s, output logic [1:0] r);
        logic ah, wh, bh;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            r = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
            if (bh) begin
                bready <= 1'h0;
                return;
            end
        end
        timeout();
    endtask
    task automatic axi_rd(input logic [11:0] a, output mpio_byte_type d, output logic [1:0] r);
        logic ah, rh;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            ah = arvalid & arready;
            rh = rvalid;
            d = rdata[7:0];
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'h0;
            if (rh) begin
                rready <= 1'h0;
                return;
            end
        end
        timeout();
    endtask
    task automatic wr(input logic [11:0] a, input mpio_byte_type d);
        axi_wr(a, d, 4'hF, rsp);
        check8("bresp", {6'h0, `MPIO_RESP_OKAY}, {6'h0, rsp});
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input mpio_byte_type e);
        axi_rd(a, rd, rsp);
        check8(nm, e, rd);
    endtask
    // Outside writer: strobe low for one cycle, then bus released
    task automatic ext_wr(input mpio_byte_type b);
        @(posedge clk);
        d_ext <= b;
        d_en <= 8'hFF;
        e_ext <= 3'h1;
        @(posedge clk);
        e_ext <= 3'h7;
        d_en <= 8'h00;
        repeat (3) @(posedge clk);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        timeout();
    end
    initial begin
        void'($urandom(35510));
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        por_rst <= 1'h0;
        e_ext <= 3'h5;
        rchk("c_dir", A_CT, 8'hFF);
        rchk("d_dir", A_DT, 8'hFF);
        rchk("e_ctrl", A_EC, 8'h07);
        rchk("e_data", A_ED, 8'h00);
        @(negedge clk);
        check8("d_oe_n", 8'hFF, d_oe_n);
        axi_rd(12'h000, rd, rsp);
        check8("rresp", {6'h0, `MPIO_RESP_SLVERR}, {6'h0, rsp});
        axi_wr(12'h004, 8'hAA, 4'hF, rsp);
        check8("bresp", {6'h0, `MPIO_RESP_SLVERR}, {6'h0, rsp});
        wr(A_EC, 8'hC8);
        rchk("e_ctrl", A_EC, 8'h00);
        wr(A_ED, 8'h05);
        @(negedge clk);
        check8("e_oe_n", 8'h00, {5'h0, e_oe_n});
        check8("e_out", 8'h05, {5'h0, e_out});
        for (int i = 0; i < 10; i++) begin
            lat = 8'($urandom);
            dir = 8'($urandom);
            v = 8'($urandom);
            wr(A_CD, lat);
            wr(A_CT, dir);
            psel <= (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($urandom));
            poe <= 8'($urandom);
            pout <= 8'($urandom);
            c_ext <= v;
            @(negedge clk);
            check8("c_out", f_cout(psel, pout, lat), c_out);
            check8("c_oe_n", f_cdir(psel, poe, dir), c_oe_n);
            rchk("c_dir_eff", A_CT, f_cdir(psel, poe, dir));
            rchk("c_data", A_CD, f_pin(f_cdir(psel, poe, dir), f_cout(psel, pout, lat), v));
        end
        wr(A_DD, 8'h5A);
        wr(A_DT, 8'h0F);
        d_ext <= 8'hC3;
        @(negedge clk);
        check8("d_out", 8'h5A, d_out);
        check8("d_oe_n", 8'h0F, d_oe_n);
        // Lane 0 off: accepted but must leave the latch alone
        axi_wr(A_DD, 8'hFF, 4'hE, rsp);
        @(negedge clk);
        check8("lane_bresp", {6'h0, `MPIO_RESP_OKAY}, {6'h0, rsp});
        check8("lane_d_out", 8'h5A, d_out);
        rchk("d_data", A_DD, f_pin(8'h0F, 8'h5A, 8'hC3));
        wr(A_AN, 8'h00);
        wr(A_EC, 8'h07);
        rchk("e_data", A_ED, 8'h05);
        wr(A_DT, 8'hFF);
        e_ext <= 3'h7;
        wr(A_EC, 8'h17);
        @(negedge clk);
        check8("mode", 8'h01, {7'h0, smode});
        v = 8'($urandom);
        ext_wr(v);
        rchk("ctrl_ibf", A_EC, 8'h97);
        rchk("psp_in", A_DD, v);
        rchk("ctrl_rd", A_EC, 8'h17);
        ext_wr(8'h3C);
        v = 8'($urandom);
        ext_wr(v);
        rchk("ctrl_ov", A_EC, 8'hB7);
        wr(A_EC, 8'h17);
        rchk("ctrl_clr", A_EC, 8'h97);
        rchk("psp_in2", A_DD, v);
        lat = 8'($urandom);
        wr(A_DD, lat);
        rchk("ctrl_obf", A_EC, 8'h57);
        @(posedge clk);
        e_ext <= 3'h2;
        @(negedge clk);
        check8("psp_oe_n", 8'h00, d_oe_n);
        check8("psp_out", lat, d_out);
        @(posedge clk);
        e_ext <= 3'h7;
        repeat (2) @(posedge clk);
        rchk("ctrl_obf0", A_EC, 8'h17);
        sys_rst <= 1'h1;
        @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        check8("latch_keep", lat, d_out);
        check8("d_oe_n", 8'hFF, d_oe_n);
        check8("mode", 8'h00, {7'h0, smode});
        @(posedge clk);
        por_rst <= 1'h1;
        @(posedge clk);
        por_rst <= 1'h0;
        @(negedge clk);
        check8("latch_por", `MPIO_LATCH_POR, d_out);
        rchk("e_ctrl", A_EC, 8'h07);
        wrap_up();
    end
endmodule
